// ===== bkp_pkg.sv
// Purpose: Shared constants for the backup-domain supply enable controller
// Assumes: AHB-Lite register bus, 32-bit word registers
// Notes: All offsets are byte addresses within a 4 KB window
`default_nettype none
package bkp_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [11:0] OFS_CTL = 12'h000;
  localparam logic [11:0] OFS_WAKE = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  localparam logic [11:0] OFS_BRST = 12'h00c;
  localparam logic [11:0] OFS_CAL = 12'h010;
  localparam logic [11:0] OFS_WORDS = 12'h040;
  localparam logic [11:0] OFS_WORDS_END = 12'h080;
  // ==========================================================
  // Field layout
  localparam int NUM_WORDS = 16;
  localparam int WORD_IDX_W = 4;
  localparam int WORD_IDX_LSB = 2;
  localparam int ADDR_W = 12;
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_ALWAYS_BIT = 1;
  localparam int CTL_PIN_BIT = 2;
  localparam int CTL_UNLK_BIT = 3;
  localparam int CTL_KEY_LSB = 8;
  localparam int KEY_W = 8;
  localparam int NUM_ALARMS = 2;
  localparam int NUM_ROLL = 4;
  localparam int WAKE_ALARM_LSB = 0;
  localparam int WAKE_ROLL_LSB = 2;
  localparam int WAKE_POL_BIT = 8;
  localparam int STAT_PIN_BIT = 0;
  localparam int STAT_ALARM_LSB = 1;
  localparam int STAT_HIB_BIT = 3;
  localparam int BRST_BIT = 0;
  localparam int CAL_W = 8;
  localparam int HTRANS_ACT_BIT = 1;
  // ==========================================================
  // Values and reset values
  localparam logic [KEY_W-1:0] UNLOCK_KEY = 8'h3a;
  localparam logic [NUM_ALARMS-1:0] RST_ALARM_EN = 2'h0;
  localparam logic [NUM_ROLL-1:0] RST_ROLL_EN = 4'h0;
  localparam logic RST_HIB_POL = 1'b1;
  localparam logic [CAL_W-1:0] RST_CAL = 8'h00;
  localparam logic RESP_OKAY = 1'b0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam logic [4:0] BRST_CYCLES = 5'h10;
  localparam logic [4:0] CNT_ONE = 5'h01;
  // Backup-domain soft reset sequencer
  typedef enum logic [0:0] {
    BR_IDLE = 1'b0,
    BR_BUSY = 1'b1
  } brst_state_e;
endpackage
`default_nettype wire

// ===== wake_if.sv
// Purpose: Wake source configuration and events between controller parts
// Assumes: Single clock domain on both sides
// Notes: ctl side owns configuration, src side owns events
`timescale 1ns/10ps
`default_nettype none
interface wake_if;
  logic [bkp_pkg::NUM_ALARMS-1:0] alarm_en;
  logic [bkp_pkg::NUM_ROLL-1:0] roll_en;
  logic [bkp_pkg::NUM_ALARMS-1:0] alarm_lvl;
  logic wake_evt;
  modport ctl (output alarm_en, output roll_en,
               input alarm_lvl, input wake_evt);
  modport src (input alarm_en, input roll_en,
               output alarm_lvl, output wake_evt);
endinterface
`default_nettype wire

// ===== sync_bank.sv
// Purpose: Two-flop synchroniser, one per bit
// Assumes: Inputs are asynchronous levels
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module sync_bank #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  // ==========================================================
  // Per-bit synchroniser stages
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_q[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta_q[i] <= d[i];
          q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== rtc_wake.sv
// Purpose: Turns clock alarm matches and rollovers into wake events
// Assumes: Match and rollover signals come from another clock domain
// Notes: Events are rising edges of the synchronised levels
`timescale 1ns/10ps
`default_nettype none
module rtc_wake (
  input wire logic clk,
  input wire logic rst,
  input wire logic [bkp_pkg::NUM_ALARMS-1:0] alarm_match,
  input wire logic [bkp_pkg::NUM_ROLL-1:0] rollover,
  wake_if.src w
);
  localparam int SW = bkp_pkg::NUM_ALARMS + bkp_pkg::NUM_ROLL;
  logic [SW-1:0] sync_s;
  logic [SW-1:0] prev_q;
  logic [SW-1:0] rise;
  // ==========================================================
  // Synchronise both alarms and all rollover strobes
  sync_bank #(.W(SW)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({rollover, alarm_match}),
    .q(sync_s)
  );
  // Previous value for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q <= '0;
    end else begin
      prev_q <= sync_s;
    end
  end
  // Two alarms and four rollover sources, each gated
  assign rise = sync_s & ~prev_q;
  assign w.alarm_lvl = sync_s[bkp_pkg::NUM_ALARMS-1:0]; // R13
  assign w.wake_evt = |(rise[bkp_pkg::NUM_ALARMS-1:0] & w.alarm_en)
      | |(rise[SW-1:bkp_pkg::NUM_ALARMS] & w.roll_en); // R13
endmodule
`default_nettype wire

// ===== supply_enable_ctrl.sv
// Purpose: Backup-domain supply enable controller with retained words
// Assumes: REF_CLK 200 MHz; RESET is the backup-domain reset only
// Notes: AHB-Lite slave, writes zero-wait, reads one wait state
//
// Functional notes
// R1: Supply enable output is high after reset.
// R2: Driving the enable output low turns the external supply off.
// R3: Wake pin high or clock alarm sets a low enable output high.
// R4: Software writes the unlock key before other control writes.
// R5: Key value in key field unlocks, releasing the output to software.
// R6: Any other key value relocks and re-enables the controller.
// R7: Software enables by unlock, set enable bit, then relock.
// R8: Always-enable holds output high until backup reset.
// R9: Clearing enable bit while unlocked drives the output low.
// R10: Relocking after a disable sets the output high again.
// R11: Wake pin acts on high level only, never on low.
// R12: Hibernate wake on the shared pin has selectable polarity.
// R13: Clock wake offers two alarms and four rollover events.
// R14: Calibration trims the timebase in one ppm steps, either sign.
// R15: Sixteen retained 32-bit data words.
// R16: Retained words survive main-device resets and hibernate.
// R17: Only the backup-domain reset clears this block.
// R18: Backup reset flag reads one until done, then zero.
// R19: Locked control writes other than the key field are ignored.
//
// The address map and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module supply_enable_ctrl (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  input wire logic SUPPLY_WAKE_IN,
  input wire logic [bkp_pkg::NUM_ALARMS-1:0] RTC_ALARM_MATCH,
  input wire logic [bkp_pkg::NUM_ROLL-1:0] RTC_ROLLOVER,
  output logic SUPPLY_EN_OUT,
  output logic HIB_WAKE,
  output logic [bkp_pkg::CAL_W-1:0] CAL_TRIM
);
  // ==========================================================
  // Declarations
  wake_if w ();
  logic accept;
  logic rd_pend_q;
  logic wr_pend_q;
  logic [bkp_pkg::ADDR_W-1:0] addr_q;
  logic addr_ok_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_d;
  logic wr_any;
  logic wr_ctl;
  logic wr_wake;
  logic wr_brst;
  logic wr_cal;
  logic wr_word;
  logic in_words;
  logic key_hit;
  logic wake_s;
  logic wake_set;
  logic en_q;
  logic always_q;
  logic unlocked_q;
  logic pin_q;
  logic hib_q;
  logic hib_pol_q;
  logic [bkp_pkg::NUM_ALARMS-1:0] alarm_en_q;
  logic [bkp_pkg::NUM_ROLL-1:0] roll_en_q;
  logic [bkp_pkg::CAL_W-1:0] cal_q;
  logic [31:0] words_q [bkp_pkg::NUM_WORDS];
  logic [bkp_pkg::WORD_IDX_W-1:0] widx;
  bkp_pkg::brst_state_e brst_q;
  logic [4:0] brst_cnt_q;
  logic brst_done;

  // ==========================================================
  // Wake source helpers
  // Clock alarm and rollover events
  rtc_wake u_rtc (
    .clk(REF_CLK),
    .rst(RESET),
    .alarm_match(RTC_ALARM_MATCH),
    .rollover(RTC_ROLLOVER),
    .w(w.src)
  );

  // Wake pin synchroniser
  sync_bank #(.W(1)) u_wsync (
    .clk(REF_CLK),
    .rst(RESET),
    .d(SUPPLY_WAKE_IN),
    .q(wake_s)
  );

  assign w.alarm_en = alarm_en_q;
  assign w.roll_en = roll_en_q;

  // ==========================================================
  // AHB-Lite address phase capture
  assign accept = HSEL & HTRANS[bkp_pkg::HTRANS_ACT_BIT] & HREADY;

  // Pending read and write flags
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      rd_pend_q <= 1'b0;
      wr_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= accept & ~HWRITE;
      wr_pend_q <= accept & HWRITE;
    end
  end

  // Address held for the data phase
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      addr_q <= '0;
      addr_ok_q <= 1'b0;
    end else if (accept) begin
      addr_q <= HADDR[bkp_pkg::ADDR_W-1:0];
      addr_ok_q <= ~|HADDR[31:bkp_pkg::ADDR_W];
    end
  end

  // Read wait state, response always OKAY
  assign HREADYOUT = ~rd_pend_q;
  assign HRESP = bkp_pkg::RESP_OKAY;
  assign HRDATA = hrdata_q;

  // ==========================================================
  // Write decode
  assign in_words = addr_ok_q && (addr_q >= bkp_pkg::OFS_WORDS)
      && (addr_q < bkp_pkg::OFS_WORDS_END)
      && (addr_q[bkp_pkg::WORD_IDX_LSB-1:0] == '0);
  assign widx = addr_q[bkp_pkg::WORD_IDX_LSB +: bkp_pkg::WORD_IDX_W];
  assign wr_any = wr_pend_q & addr_ok_q
      & (brst_q == bkp_pkg::BR_IDLE); // R18
  assign wr_ctl = wr_any & (addr_q == bkp_pkg::OFS_CTL);
  assign wr_wake = wr_any & (addr_q == bkp_pkg::OFS_WAKE);
  assign wr_brst = wr_any & (addr_q == bkp_pkg::OFS_BRST);
  assign wr_cal = wr_any & (addr_q == bkp_pkg::OFS_CAL);
  assign wr_word = wr_any & in_words;
  // Unmapped or unaligned writes match no strobe and are dropped

  // Key field compare
  assign key_hit = HWDATA[bkp_pkg::CTL_KEY_LSB +: bkp_pkg::KEY_W]
      == bkp_pkg::UNLOCK_KEY;

  // ==========================================================
  // Supply control
  // Lock state follows the key field of every control write
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      unlocked_q <= 1'b0;
    end else if (brst_done) begin
      unlocked_q <= 1'b0;
    end else if (wr_ctl) begin
      unlocked_q <= key_hit; // R5 R6
    end
  end

  // Wake only on a high pin level or a clock event while off
  assign wake_set = ~en_q & (wake_s | w.wake_evt); // R3 R11

  // Enable bit: wake set wins over a clearing write
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      en_q <= 1'b1; // R1
    end else if (brst_done) begin
      en_q <= 1'b1; // R1
    end else if (wake_set) begin
      en_q <= 1'b1; // R3
    end else if (wr_ctl & ~key_hit) begin
      en_q <= 1'b1; // R6 R10
    end else if (wr_ctl & unlocked_q) begin
      en_q <= HWDATA[bkp_pkg::CTL_EN_BIT]; // R9 R7
    end
  end
  // Locked writes carrying the key only unlock, fields untouched R19

  // Always-enable: set once, cleared only by backup reset
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      always_q <= 1'b0;
    end else if (brst_done) begin
      always_q <= 1'b0; // R8
    end else if (wr_ctl & key_hit & unlocked_q
                 & HWDATA[bkp_pkg::CTL_ALWAYS_BIT]) begin
      always_q <= 1'b1; // R8
    end
  end

  // Always-enable wins over a cleared enable bit
  // Output pin register, low means supply off
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      pin_q <= 1'b1; // R1
    end else begin
      pin_q <= always_q | en_q; // R2 R8
    end
  end
  assign SUPPLY_EN_OUT = pin_q;

  // ==========================================================
  // Hibernate wake on the shared pin
  // Level match against the configured polarity
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      hib_q <= 1'b0;
    end else begin
      hib_q <= (wake_s == hib_pol_q); // R12
    end
  end
  assign HIB_WAKE = hib_q;

  // Wake configuration register
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      alarm_en_q <= bkp_pkg::RST_ALARM_EN;
      roll_en_q <= bkp_pkg::RST_ROLL_EN;
      hib_pol_q <= bkp_pkg::RST_HIB_POL;
    end else if (brst_done) begin
      alarm_en_q <= bkp_pkg::RST_ALARM_EN;
      roll_en_q <= bkp_pkg::RST_ROLL_EN;
      hib_pol_q <= bkp_pkg::RST_HIB_POL;
    end else if (wr_wake) begin
      alarm_en_q <= HWDATA[bkp_pkg::WAKE_ALARM_LSB +:
                           bkp_pkg::NUM_ALARMS]; // R13
      roll_en_q <= HWDATA[bkp_pkg::WAKE_ROLL_LSB +:
                          bkp_pkg::NUM_ROLL]; // R13
      hib_pol_q <= HWDATA[bkp_pkg::WAKE_POL_BIT]; // R12
    end
  end

  // ==========================================================
  // Calibration trim, signed ppm
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      cal_q <= bkp_pkg::RST_CAL;
    end else if (brst_done) begin
      cal_q <= bkp_pkg::RST_CAL;
    end else if (wr_cal) begin
      cal_q <= HWDATA[bkp_pkg::CAL_W-1:0]; // R14
    end
  end
  assign CAL_TRIM = cal_q;

  // ==========================================================
  // Retained data words
  // Cleared only by the backup-domain reset
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      for (int i = 0; i < bkp_pkg::NUM_WORDS; i++) begin
        words_q[i] <= '0; // R17
      end
    end else if (brst_done) begin
      for (int i = 0; i < bkp_pkg::NUM_WORDS; i++) begin
        words_q[i] <= '0;
      end
    end else if (wr_word) begin
      words_q[widx] <= HWDATA; // R15 R16
    end
  end

  // ==========================================================
  // Backup-domain soft reset sequencer
  // Done pulse lasts one cycle and restores the reset values of the control, wake, trim and word registers
  assign brst_done = (brst_q == bkp_pkg::BR_BUSY)
      && (brst_cnt_q == (bkp_pkg::BRST_CYCLES - bkp_pkg::CNT_ONE));

  // State and cycle count
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      brst_q <= bkp_pkg::BR_IDLE;
      brst_cnt_q <= '0;
    end else begin
      case (brst_q)
        bkp_pkg::BR_IDLE: begin
          brst_cnt_q <= '0;
          if (wr_brst & HWDATA[bkp_pkg::BRST_BIT]) begin
            brst_q <= bkp_pkg::BR_BUSY; // R18
          end
        end
        bkp_pkg::BR_BUSY: begin
          brst_cnt_q <= brst_cnt_q + bkp_pkg::CNT_ONE;
          if (brst_done) begin
            brst_q <= bkp_pkg::BR_IDLE; // R18
          end
        end
        default: begin
          brst_q <= bkp_pkg::BR_IDLE;
          brst_cnt_q <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // Read data mux
  always_comb begin
    rd_d = bkp_pkg::RD_ZERO;
    if (!addr_ok_q) begin
      rd_d = bkp_pkg::RD_ZERO;
    end else if (addr_q == bkp_pkg::OFS_CTL) begin
      rd_d[bkp_pkg::CTL_EN_BIT] = en_q;
      rd_d[bkp_pkg::CTL_ALWAYS_BIT] = always_q;
      rd_d[bkp_pkg::CTL_PIN_BIT] = pin_q;
      rd_d[bkp_pkg::CTL_UNLK_BIT] = unlocked_q;
    end else if (addr_q == bkp_pkg::OFS_WAKE) begin
      rd_d[bkp_pkg::WAKE_ALARM_LSB +: bkp_pkg::NUM_ALARMS] = alarm_en_q;
      rd_d[bkp_pkg::WAKE_ROLL_LSB +: bkp_pkg::NUM_ROLL] = roll_en_q;
      rd_d[bkp_pkg::WAKE_POL_BIT] = hib_pol_q;
    end else if (addr_q == bkp_pkg::OFS_STAT) begin
      rd_d[bkp_pkg::STAT_PIN_BIT] = wake_s;
      rd_d[bkp_pkg::STAT_ALARM_LSB +: bkp_pkg::NUM_ALARMS] = w.alarm_lvl;
      rd_d[bkp_pkg::STAT_HIB_BIT] = hib_q;
    end else if (addr_q == bkp_pkg::OFS_BRST) begin
      rd_d[bkp_pkg::BRST_BIT] = (brst_q == bkp_pkg::BR_BUSY); // R18
    end else if (addr_q == bkp_pkg::OFS_CAL) begin
      rd_d[bkp_pkg::CAL_W-1:0] = cal_q;
    end else if (in_words) begin
      rd_d = words_q[widx]; // R15
    end
  end

  // Read data register, loaded in the wait cycle
  // Holds between reads, so HRDATA stands until the next one
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      hrdata_q <= bkp_pkg::RD_ZERO;
    end else if (rd_pend_q) begin
      hrdata_q <= rd_d;
    end
  end
endmodule
`default_nettype wire

// ===== supply_enable_ctrl_properties.sv
// Purpose: Port-level properties of the supply enable controller
// Assumes: One clock domain, HREADY tied to HREADYOUT
// Notes: Bound to every controller instance
`timescale 1ns/10ps
`default_nettype none
module supply_enable_ctrl_properties (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic SUPPLY_WAKE_IN,
  input wire logic [bkp_pkg::NUM_ALARMS-1:0] RTC_ALARM_MATCH,
  input wire logic [bkp_pkg::NUM_ROLL-1:0] RTC_ROLLOVER,
  input wire logic SUPPLY_EN_OUT,
  input wire logic HIB_WAKE,
  input wire logic [bkp_pkg::CAL_W-1:0] CAL_TRIM
);
  // ====================
  // Data phase tracking
  logic wr_q;
  logic rd_q;
  logic [31:0] adr_q;
  logic quiet;
  // Remember the accepted address phase
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      adr_q <= 32'h0000_0000;
    end else begin
      wr_q <= HSEL && HTRANS[1] && HREADY && HWRITE;
      rd_q <= HSEL && HTRANS[1] && HREADY && !HWRITE;
      adr_q <= HADDR;
    end
  end
  // No wake source and no bus activity
  assign quiet = !SUPPLY_WAKE_IN && !HSEL && RTC_ALARM_MATCH == 2'h0
    && RTC_ROLLOVER == 4'h0;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  // ====================
  // Properties
  reset_vals_a: assert property (
    $fell(RESET) |-> SUPPLY_EN_OUT && !HIB_WAKE && CAL_TRIM == 8'h00)
    else $error("outputs wrong after reset");
  wake_sets_a: assert property (
    SUPPLY_WAKE_IN [*6] |-> SUPPLY_EN_OUT)
    else $error("wake level did not raise enable");
  low_holds_a: assert property (
    quiet [*6] ##0 !SUPPLY_EN_OUT |=> !SUPPLY_EN_OUT)
    else $error("enable rose without a wake cause");
  relock_high_a: assert property (
    wr_q && adr_q == {20'h00000, bkp_pkg::OFS_CTL}
    && HWDATA[15:8] != bkp_pkg::UNLOCK_KEY |-> ##2 SUPPLY_EN_OUT)
    else $error("relock did not raise enable");
  hib_stable_a: assert property (
    (!HSEL && $stable(SUPPLY_WAKE_IN)) [*6] |-> $stable(HIB_WAKE))
    else $error("hibernate wake moved with steady pin");
  cal_load_a: assert property (
    wr_q && adr_q == {20'h00000, bkp_pkg::OFS_CAL}
    |-> ##2 CAL_TRIM == $past(HWDATA[7:0], 2))
    else $error("trim output not loaded");
  read_wait_a: assert property (
    rd_q |-> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  bus_okay_a: assert property (
    HSEL && HTRANS[1] |=> HRESP == bkp_pkg::RESP_OKAY)
    else $error("response not okay");
endmodule
bind supply_enable_ctrl supply_enable_ctrl_properties chk (
  .REF_CLK(REF_CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SUPPLY_WAKE_IN(SUPPLY_WAKE_IN),
  .RTC_ALARM_MATCH(RTC_ALARM_MATCH), .RTC_ROLLOVER(RTC_ROLLOVER),
  .SUPPLY_EN_OUT(SUPPLY_EN_OUT), .HIB_WAKE(HIB_WAKE), .CAL_TRIM(CAL_TRIM)
);
`default_nettype wire

// ===== pmic_model.sv
// Purpose: External supply with an active high enable
// Assumes: Enable seen on the reference clock
// Notes: Unknown enable gives an unknown rail
`timescale 1ns/10ps
`default_nettype none
module pmic_model #(
  parameter int RAMP = 3
) (
  input wire logic clk,
  input wire logic en,
  output logic rail_up
);
  // ====================
  // Rail ramp
  int cnt = 0;
  initial rail_up = 1'b0;
  // Rail follows enable RAMP cycles later
  always @(posedge clk) begin
    if (en !== 1'b0 && en !== 1'b1) begin
      rail_up <= 1'bx;
    end else if (en === rail_up) begin
      cnt <= 0;
    end else if (cnt == RAMP - 1) begin
      rail_up <= en;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ===== backup_supply_enable_ctrl_tb.sv
// Purpose: Self-checking bench for the supply enable controller
// Assumes: One bus master, HREADY fed from HREADYOUT
// Notes: Model tracks lock state, enable and stored registers
`timescale 1ns/10ps
`default_nettype none
module backup_supply_enable_ctrl_tb;
  // ====================
  // Signals and model state
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic wake_in = 1'b0;
  logic [5:0] src = 6'h00;
  logic hrdy, hresp, en_out, hib, rail;
  logic [31:0] hrdata, rv;
  logic [7:0] cal;
  logic [31:0] mem [int];
  int err_total = 0, num_checks = 0, cyc = 0, i;
  bit unl, en, alw;
  // Clock and hang guard
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  supply_enable_ctrl dut (
    .REF_CLK(clk), .RESET(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hrdy), .HREADYOUT(hrdy), .HRESP(hresp), .HRDATA(hrdata),
    .SUPPLY_WAKE_IN(wake_in), .RTC_ALARM_MATCH(src[1:0]),
    .RTC_ROLLOVER(src[5:2]), .SUPPLY_EN_OUT(en_out), .HIB_WAKE(hib),
    .CAL_TRIM(cal)
  );
  pmic_model #(.RAMP(3)) supply (.clk(clk), .en(en_out), .rail_up(rail));
  // ====================
  // Tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_reg(input string n, input logic [31:0] e,
                         input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_pin(input string n, input logic e, input logic g);
    chk_reg(n, {31'h0, e}, {31'h0, g});
  endtask
  // One single transfer, waits on ready in both phases
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h00000, a};
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rv = hrdata;
  endtask
  task automatic mreset();
    mem.delete();
    for (int k = 0; k < 16; k++) mem[bkp_pkg::OFS_WORDS + 4 * k] = 32'h0;
    mem[bkp_pkg::OFS_WAKE] = {23'h0, bkp_pkg::RST_HIB_POL, 8'h00};
    mem[bkp_pkg::OFS_CAL] = 32'h0;
    mem[bkp_pkg::OFS_BRST] = 32'h0;
    unl = 0;
    en = 1;
    alw = 0;
  endtask
  // Write and update the model
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    if (a == bkp_pkg::OFS_CTL) begin
      if (d[15:8] != bkp_pkg::UNLOCK_KEY) begin
        unl = 0;
        en = 1;
      end else if (unl) begin
        en = d[0];
        alw |= d[1];
      end else begin
        unl = 1;
      end
    end else if (mem.exists(a)) begin
      mem[a] = d & (a == bkp_pkg::OFS_WAKE ? 32'h13f :
        a == bkp_pkg::OFS_CAL ? 32'hff : a == bkp_pkg::OFS_BRST ?
        32'h1 : 32'hffff_ffff);
    end
  endtask
  task automatic rd(input logic [11:0] a);
    logic [31:0] e;
    e = mem.exists(a) ? mem[a] : 32'h0;
    if (a == bkp_pkg::OFS_CTL) e = {28'h0, unl, en | alw, alw, en};
    if (a == bkp_pkg::OFS_STAT) begin
      e = {28'h0, wake_in == mem[bkp_pkg::OFS_WAKE][8], src[1:0], wake_in};
    end
    bus(1'b0, a, 32'h0);
    chk_reg($sformatf("reg %h", a), e, rv);
  endtask
  task automatic pins();
    repeat (6) @(posedge clk);
    chk_pin("supply enable", en | alw, en_out);
    chk_pin("supply rail", en | alw, rail);
    chk_pin("hib wake", wake_in == mem[bkp_pkg::OFS_WAKE][8], hib);
    chk_reg("trim", mem[bkp_pkg::OFS_CAL], {24'h0, cal});
  endtask
  task automatic pulse(input logic [5:0] s, input bit hit);
    src <= s;
    repeat (4) @(posedge clk);
    src <= 6'h00;
    repeat (4) @(posedge clk);
    if (hit) en = 1;
    pins();
  endtask
  // ====================
  // Main sequence
  initial begin
    void'($urandom(8061));
    mreset();
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    pins();
    rd(bkp_pkg::OFS_CTL);
    rd(bkp_pkg::OFS_WAKE);
    for (i = 0; i < 16; i++) wr(12'(bkp_pkg::OFS_WORDS + 4 * i), $urandom());
    for (i = 0; i < 16; i++) rd(12'(bkp_pkg::OFS_WORDS + 4 * i));
    wr(12'h020, $urandom());
    rd(12'h020);
    wr(bkp_pkg::OFS_CTL, 32'h2);
    wr(bkp_pkg::OFS_CTL, 32'h3a00);
    rd(bkp_pkg::OFS_CTL);
    wr(bkp_pkg::OFS_CTL, 32'h3a00);
    repeat (20) @(posedge clk);
    pins();
    wake_in <= 1'b1;
    en = 1;
    repeat (4) @(posedge clk);
    pins();
    rd(bkp_pkg::OFS_STAT);
    wake_in <= 1'b0;
    repeat (4) @(posedge clk);
    wr(bkp_pkg::OFS_CTL, 32'h3a00);
    pins();
    wr(bkp_pkg::OFS_CTL, 32'h3a01);
    pins();
    wr(bkp_pkg::OFS_CTL, 32'h3a00);
    wr(bkp_pkg::OFS_CTL, 32'h0);
    pins();
    for (i = 0; i < 6; i++) begin
      wr(bkp_pkg::OFS_WAKE, 32'h100 | (32'h1 << i));
      wr(bkp_pkg::OFS_CTL, 32'h3a00);
      wr(bkp_pkg::OFS_CTL, 32'h3a00);
      pulse(~(6'h1 << i), 1'b0);
      pulse(6'h1 << i, 1'b1);
    end
    wr(bkp_pkg::OFS_CAL, $urandom());
    pins();
    rd(bkp_pkg::OFS_CAL);
    wr(bkp_pkg::OFS_WAKE, 32'h0);
    pins();
    rd(bkp_pkg::OFS_STAT);
    wr(bkp_pkg::OFS_WAKE, 32'h100);
    wr(bkp_pkg::OFS_CTL, 32'h3a00);
    wr(bkp_pkg::OFS_CTL, 32'h3a02);
    wr(bkp_pkg::OFS_CTL, 32'h3a00);
    pins();
    wr(bkp_pkg::OFS_BRST, 32'h1);
    rd(bkp_pkg::OFS_BRST);
    for (i = 0; i < 40 && rv[0] !== 1'b0; i++) begin
      bus(1'b0, bkp_pkg::OFS_BRST, 32'h0);
    end
    mreset();
    rd(bkp_pkg::OFS_BRST);
    rd(bkp_pkg::OFS_WORDS);
    wr(bkp_pkg::OFS_CTL, 32'h3a00);
    wr(bkp_pkg::OFS_CTL, 32'h3a00);
    pins();
    close_out();
  end
endmodule
`default_nettype wire
